// ### core/kbpi_pin_if.sv
// keyboard configuration toward the pin sharing logic and the usable pin set back
// assumes both ends run on the same clock
interface kbpi_pin_if;
  logic [7:0] pin_enable;
  logic [7:0] polarity;
  logic [7:0] kb_active;
  modport ctrl (output pin_enable, output polarity, input kb_active);
  modport mux (input pin_enable, input polarity, output kb_active);
endinterface

// ### core/kbpi_pin_mux.sv
// pin sharing between port, adc and keyboard: direction, pulls, port read path
// assumes port direction, pullup and adc select arrive synchronous to pclk
module kbpi_pin_mux (
  input  wire logic       pclk,
  input  wire logic       presetn,
  kbpi_pin_if.mux         cfg,
  input  wire logic [7:0] pad_in,
  input  wire logic [7:0] port_direction,
  input  wire logic [7:0] port_pullup_enable,
  input  wire logic [7:0] adc_select,
  input  wire logic [7:0] port_out_data,
  output logic      [7:0] pad_out,
  output logic      [7:0] pad_oe,
  output logic      [7:0] pull_up,
  output logic      [7:0] pull_down,
  output logic      [7:0] port_in_data
);
  kbpi_pkg::kbpi_mux_t st_reg;
  kbpi_pkg::kbpi_mux_t st_next;

  // adc selection takes the pin away from the keyboard
  assign cfg.kb_active = cfg.pin_enable & ~adc_select;

  // per-pin function selection
  always_comb begin
    st_next = st_reg;
    st_next.pad_out = port_out_data;
    st_next.pad_oe = port_direction & ~cfg.pin_enable & ~adc_select;
    st_next.pull_up = port_pullup_enable & ~adc_select
                    & ((~cfg.pin_enable & ~port_direction)
                    | (cfg.pin_enable & ~cfg.polarity));
    st_next.pull_down = port_pullup_enable & ~adc_select
                      & cfg.pin_enable & cfg.polarity;
    st_next.port_in = pad_in & ~port_direction & ~adc_select;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pad_out      = st_reg.pad_out;
  assign pad_oe       = st_reg.pad_oe;
  assign pull_up      = st_reg.pull_up;
  assign pull_down    = st_reg.pull_down;
  assign port_in_data = st_reg.port_in;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_kb_forces_input;
    (cfg.pin_enable[7] && port_direction[7]) |=> !pad_oe[7];
  endproperty
  a_kb_forces_input: assert property (p_kb_forces_input)
    else $error("keyboard pin driven as output");

  property p_pulldown_swap;
    (cfg.pin_enable[6] && cfg.polarity[6] && port_pullup_enable[6] && !adc_select[6])
      |=> (pull_down[6] && !pull_up[6]);
  endproperty
  a_pulldown_swap: assert property (p_pulldown_swap)
    else $error("pulldown not chosen for high polarity");

  property p_adc_no_pull;
    adc_select[5] |=> (!pull_up[5] && !pull_down[5] && !pad_oe[5] && !port_in_data[5]);
  endproperty
  a_adc_no_pull: assert property (p_adc_no_pull)
    else $error("adc pin still has port or pull function");
endmodule

// ### core/kbpi_pkg.sv
// constants, register map and state types of the keyboard pin interrupt block
// assumes a 32-bit apb bus and eight shared keyboard pins
package kbpi_pkg;
  localparam int unsigned NPIN       = 8;
  localparam int unsigned AW         = 12;
  // register byte offsets
  localparam logic [AW-1:0] OFS_SC   = 12'h000;
  localparam logic [AW-1:0] OFS_PE   = 12'h004;
  localparam logic [AW-1:0] OFS_IST  = 12'h008;
  localparam logic [AW-1:0] OFS_IMSK = 12'h00c;
  // status/control field positions
  localparam int unsigned SC_POL_LO  = 4;
  localparam int unsigned SC_FLAG    = 3;
  localparam int unsigned SC_ACK     = 2;
  localparam int unsigned SC_IE      = 1;
  localparam int unsigned SC_MODE    = 0;
  // polarity exists only on pins 7:4
  localparam logic [7:0]  POL_MASK   = 8'hf0;
  // sticky event bits
  localparam int unsigned NEV        = 2;
  localparam int unsigned EV_EDGE    = 0;
  localparam int unsigned EV_HELD    = 1;
  // reset values
  localparam logic [7:0]  RST_SC     = 8'h00;
  localparam logic [7:0]  RST_PE     = 8'h00;
  localparam logic [1:0]  RST_EV     = 2'h0;

  typedef enum logic [2:0] {KBPI_SEL_SC, KBPI_SEL_PE, KBPI_SEL_IST, KBPI_SEL_IMSK,
                            KBPI_SEL_NONE} kbpi_sel_t;

  typedef struct packed {
    logic [7:0]  pol;
    logic        flag;
    logic        ie;
    logic        mode;
    logic [7:0]  pe;
    logic [1:0]  ist;
    logic [1:0]  imsk;
    logic [7:0]  asrt_prev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        kb_irq;
    logic        irq;
    logic        wake;
  } kbpi_state_t;

  typedef struct packed {
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] port_in;
  } kbpi_mux_t;
endpackage

// ### core/kbpi_top.sv
// keyboard pin interrupt: apb registers, edge/level detection, flag, interrupts, wake
// assumes pad inputs synchronous to pclk; port and adc controls come from outside
// Notes on behaviour
// - keyboard pin is always an input
// - port pullup enable still drives pull
// - pin level readable via port when input
// - adc selection disables port, keyboard and pulls
// - pins 3:0 detect only falling/low
// - high polarity with pullup gives pulldown
// - pullup only in the two listed cases
// - polarity bit 0 falling/low, 1 rising/high
// - flag sets on edge at enabled pin
// - acknowledge write clears flag, reads zero
// - level mode holds flag while asserted
// - interrupt request when flag and enable
// - mode bit: 0 edge, 1 edge-and-level
// - pin enable bit makes pin keyboard
// - keyboard event wakes from stop and wait (wake from wait here only with interrupt enable set)
// - edge means two consecutive opposite samples
// - stop mode uses asynchronous level wake
module kbpi_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pad_in,
  input  wire logic [7:0]  port_direction,
  input  wire logic [7:0]  port_pullup_enable,
  input  wire logic [7:0]  adc_select,
  input  wire logic [7:0]  port_out_data,
  output logic      [7:0]  pad_out,
  output logic      [7:0]  pad_oe,
  output logic      [7:0]  pull_up,
  output logic      [7:0]  pull_down,
  output logic      [7:0]  port_in_data,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  output logic             kb_irq,
  output logic             irq,
  output logic             wake
);
  kbpi_pkg::kbpi_state_t st_reg;
  kbpi_pkg::kbpi_state_t st_next;
  kbpi_pin_if            pin_cfg ();

  logic [7:0]          pol_eff;
  logic [7:0]          asrt_now;
  logic [7:0]          edge_vec;
  logic                edge_hit;
  logic                level_any;
  logic                acc;
  logic                wr_acc;
  logic                ack_wr;
  kbpi_pkg::kbpi_sel_t sel;
  logic                wake_async;

  // level seen as asserted for the chosen polarity
  function automatic logic [7:0] assert_level(input logic [7:0] lvl, input logic [7:0] pol);
    assert_level = ~(lvl ^ pol);
  endfunction

  // word decode of the apb address
  function automatic kbpi_pkg::kbpi_sel_t reg_sel(input logic [11:0] a);
    case (a)
      kbpi_pkg::OFS_SC:   reg_sel = kbpi_pkg::KBPI_SEL_SC;
      kbpi_pkg::OFS_PE:   reg_sel = kbpi_pkg::KBPI_SEL_PE;
      kbpi_pkg::OFS_IST:  reg_sel = kbpi_pkg::KBPI_SEL_IST;
      kbpi_pkg::OFS_IMSK: reg_sel = kbpi_pkg::KBPI_SEL_IMSK;
      default:            reg_sel = kbpi_pkg::KBPI_SEL_NONE;
    endcase
  endfunction

  // configuration toward the pin sharing logic
  assign pin_cfg.pin_enable = st_reg.pe;
  assign pin_cfg.polarity   = pol_eff;

  kbpi_pin_mux u_mux (
    .pclk               (pclk),
    .presetn            (presetn),
    .cfg                (pin_cfg),
    .pad_in             (pad_in),
    .port_direction     (port_direction),
    .port_pullup_enable (port_pullup_enable),
    .adc_select         (adc_select),
    .port_out_data      (port_out_data),
    .pad_out            (pad_out),
    .pad_oe             (pad_oe),
    .pull_up            (pull_up),
    .pull_down          (pull_down),
    .port_in_data       (port_in_data)
  );

  // detection terms
  always_comb begin
    pol_eff   = st_reg.pol & kbpi_pkg::POL_MASK;
    asrt_now  = assert_level(pad_in, pol_eff) & pin_cfg.kb_active;
    edge_vec  = asrt_now & ~st_reg.asrt_prev;
    edge_hit  = |edge_vec;
    level_any = st_reg.mode & (|asrt_now);
  end

  // bus handshake terms, one wait state per access
  always_comb begin
    sel    = reg_sel(paddr);
    acc    = psel & penable & st_reg.pready;
    wr_acc = acc & pwrite & ~st_reg.pslverr;
    ack_wr = wr_acc & (sel == kbpi_pkg::KBPI_SEL_SC) & pwdata[kbpi_pkg::SC_ACK];
  end

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.asrt_prev = asrt_now;
    // bus answer
    st_next.pready  = psel & penable & ~st_reg.pready;
    st_next.pslverr = 1'b0;
    if (psel & penable & ~st_reg.pready) begin
      st_next.pslverr = (sel == kbpi_pkg::KBPI_SEL_NONE);
      st_next.prdata  = 32'h00000000;
      if (!pwrite) begin
        case (sel)
          kbpi_pkg::KBPI_SEL_SC: begin
            st_next.prdata[7:0] = {pol_eff[7:4], st_reg.flag, 1'b0,
                                   st_reg.ie, st_reg.mode};
          end
          kbpi_pkg::KBPI_SEL_PE: begin
            st_next.prdata[7:0] = st_reg.pe;
          end
          kbpi_pkg::KBPI_SEL_IST: begin
            st_next.prdata[1:0] = st_reg.ist;
          end
          kbpi_pkg::KBPI_SEL_IMSK: begin
            st_next.prdata[1:0] = st_reg.imsk;
          end
          default: begin
            st_next.prdata = 32'h00000000;
          end
        endcase
      end
    end
    // register writes
    if (wr_acc) begin
      case (sel)
        kbpi_pkg::KBPI_SEL_SC: begin
          st_next.pol  = pwdata[7:0] & kbpi_pkg::POL_MASK;
          st_next.ie   = pwdata[kbpi_pkg::SC_IE];
          st_next.mode = pwdata[kbpi_pkg::SC_MODE];
        end
        kbpi_pkg::KBPI_SEL_PE: begin
          st_next.pe = pwdata[7:0];
        end
        kbpi_pkg::KBPI_SEL_IST: begin
          st_next.ist = st_reg.ist & ~pwdata[1:0];
        end
        kbpi_pkg::KBPI_SEL_IMSK: begin
          st_next.imsk = pwdata[1:0];
        end
        default: begin
          st_next.imsk = st_reg.imsk;
        end
      endcase
    end
    // flag: set wins over acknowledge
    if (ack_wr) begin
      st_next.flag = 1'b0;
    end
    if (edge_hit | level_any) begin
      st_next.flag = 1'b1;
    end
    // sticky events, set wins over clear
    if (edge_hit) begin
      st_next.ist[kbpi_pkg::EV_EDGE] = 1'b1;
    end
    if (ack_wr & level_any) begin
      st_next.ist[kbpi_pkg::EV_HELD] = 1'b1;
    end
    // request outputs follow the next state
    st_next.kb_irq = st_next.flag & st_next.ie;
    st_next.irq    = |(st_next.ist & st_next.imsk);
    st_next.wake   = st_next.kb_irq & (wait_mode | stop_mode);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= '0;
      st_reg.pol  <= kbpi_pkg::RST_SC;
      st_reg.pe   <= kbpi_pkg::RST_PE;
      st_reg.ist  <= kbpi_pkg::RST_EV;
      st_reg.imsk <= kbpi_pkg::RST_EV;
    end else begin
      st_reg <= st_next;
    end
  end

  // stop mode: clocks halted, so an asserted level wakes without the edge logic
  assign wake_async = stop_mode & (|asrt_now);

  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign kb_irq  = st_reg.kb_irq;
  assign irq     = st_reg.irq;
  assign wake    = st_reg.wake | wake_async; // asynchronous path while clock stands

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ack_clears;
    (ack_wr && !edge_hit && !level_any) |=> !st_reg.flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledge did not clear flag");

  property p_edge_sets;
    edge_hit |=> (st_reg.flag && st_reg.ist[0]);
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge did not set flag");

  property p_level_holds;
    (st_reg.mode && (|asrt_now) && !wr_acc) ##1 (st_reg.mode && (|asrt_now))
      |=> st_reg.flag [*1];
  endproperty
  a_level_holds: assert property (p_level_holds)
    else $error("flag dropped while level asserted");

  property p_irq_req;
    kb_irq == (st_reg.flag && st_reg.ie);
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("interrupt request mismatch");

  property p_low_pins_falling;
    st_reg.pol[3:0] == 4'h0;
  endproperty
  a_low_pins_falling: assert property (p_low_pins_falling)
    else $error("pins 3:0 have polarity");

  property p_ack_reads_zero;
    (psel && penable && !pready && !pwrite && sel == kbpi_pkg::KBPI_SEL_SC)
      |=> (pready && !prdata[2]);
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero)
    else $error("acknowledge bit read nonzero");

  property p_edge_mode_quiet;
    (!st_reg.mode && !st_reg.flag && !edge_hit) |=> !st_reg.flag;
  endproperty
  a_edge_mode_quiet: assert property (p_edge_mode_quiet)
    else $error("flag set without edge in edge mode");

  property p_fall_pin0;
    (pin_cfg.kb_active[0] && $past(pin_cfg.kb_active[0]) && $past(pad_in[0])
      && !pad_in[0]) |=> st_reg.flag;
  endproperty
  a_fall_pin0: assert property (p_fall_pin0)
    else $error("falling edge on pin 0 missed");

  // with no pin enabled the flag never moves in edge mode
  property p_disabled_pin_silent;
    (st_reg.pe == 8'h00 && !st_reg.mode && !st_reg.flag) |=> !st_reg.flag;
  endproperty
  a_disabled_pin_silent: assert property (p_disabled_pin_silent)
    else $error("disabled pin produced an event");

  // stop mode wake worked out again from the raw pins
  property p_stop_wake;
    (stop_mode && (|(~(pad_in ^ st_reg.pol) & st_reg.pe & ~adc_select))) |-> wake;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("no wake in stop mode");

  // level mode sets the flag from any asserted usable pin
  property p_level_sets;
    (st_reg.mode && (|(~(pad_in ^ st_reg.pol) & st_reg.pe & ~adc_select))) |=> st_reg.flag;
  endproperty
  a_level_sets: assert property (p_level_sets)
    else $error("level mode left flag clear");

  // acknowledge against a held level is refused and logged
  property p_ack_refused;
    (st_reg.mode && ack_wr && (|asrt_now)) |=> (st_reg.flag && st_reg.ist[kbpi_pkg::EV_HELD]);
  endproperty
  a_ack_refused: assert property (p_ack_refused)
    else $error("acknowledge cleared a held flag");

  // rising edge on a high polarity pin
  property p_rise_pin4;
    (st_reg.pe[4] && st_reg.pol[4] && !adc_select[4] && $past(st_reg.pe[4])
      && $past(st_reg.pol[4]) && !$past(adc_select[4]) && !$past(pad_in[4]) && pad_in[4])
      |=> st_reg.flag;
  endproperty
  a_rise_pin4: assert property (p_rise_pin4)
    else $error("rising edge on pin 4 missed");

  // pending enabled request wakes from wait
  property p_wake_wait;
    (st_reg.flag && st_reg.ie && wait_mode && !wr_acc) |=> wake;
  endproperty
  a_wake_wait: assert property (p_wake_wait)
    else $error("no wake in wait mode");

  // enable off leaves the flag for polling only
  property p_poll_only;
    !st_reg.ie |-> !kb_irq;
  endproperty
  a_poll_only: assert property (p_poll_only)
    else $error("request raised with enable off");

  // pin enables read back as stored
  property p_pe_readback;
    (psel && penable && !pready && !pwrite && sel == kbpi_pkg::KBPI_SEL_PE)
      |=> (prdata[7:0] == $past(st_reg.pe));
  endproperty
  a_pe_readback: assert property (p_pe_readback)
    else $error("pin enables read back wrong");

  // polarity field reads back on pins 7:4
  property p_pol_readback;
    (psel && penable && !pready && !pwrite && sel == kbpi_pkg::KBPI_SEL_SC)
      |=> (prdata[7:4] == $past(st_reg.pol[7:4]));
  endproperty
  a_pol_readback: assert property (p_pol_readback)
    else $error("polarity field read back wrong");

  // configuration is clear when reset lets go
  property p_reset_clear;
    $rose(presetn) |-> (st_reg.pe == 8'h00 && st_reg.pol == 8'h00
      && !st_reg.ie && !st_reg.mode);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("configuration not cleared by reset");

  c_edge_irq:   cover property (edge_hit && st_reg.ie ##1 kb_irq);
  c_level_held: cover property (ack_wr && level_any);
  c_unmapped:   cover property (pready && pslverr);
  c_stop_wake:  cover property (stop_mode && wake);
  c_wait_wake:  cover property (wait_mode && wake);
endmodule

// ### sim/kbpi_keys.sv
// keyboard switch model: each pin idles at its deasserted level, a press drives it asserted
// assumes the bench gives the press set and the active polarity of each pin
module kbpi_keys (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] press,
  input  wire logic [7:0] active_high,
  output logic      [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pins return to the deasserted level before any new edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_in <= ~active_high;
    end else begin
      pad_in <= ~(press ^ active_high);
    end
  end
endmodule

// ### sim/kbpi_top_tb.sv
// self-checking bench: apb register access, pin sharing, edge/level flag, interrupts, wake
// assumes the switch model drives the pads and the bench drives port and adc controls
module kbpi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        stop_m, wait_m, kb_irq, irq, wake, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  press, ahigh, pad_in, dir, pue, adc, pod, en, pol;
  logic [7:0]  pad_out, pad_oe, pull_up, pull_down, port_in_data;
  int          fails, compares;

  // bus clock at 40 MHz
  always #12.5 pclk = ~pclk;

  kbpi_keys keys (.pclk(pclk), .presetn(presetn), .press(press), .active_high(ahigh),
                  .pad_in(pad_in));

  kbpi_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .port_direction(dir), .port_pullup_enable(pue),
    .adc_select(adc), .port_out_data(pod), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up(pull_up), .pull_down(pull_down), .port_in_data(port_in_data),
    .stop_mode(stop_m), .wait_mode(wait_m), .kb_irq(kb_irq), .irq(irq), .wake(wake));

  // verdict and end of run
  task conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one comparison, reported at once on mismatch
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer: setup, access held until pready sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, r, exp);
  endtask

  task settle;
    repeat (4) @(posedge pclk);
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    conclude();
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    press = 0; ahigh = 8'hf0; stop_m = 0; wait_m = 0;
    dir = 8'hf3; pue = 8'hff; adc = 8'h80; pod = 8'ha5;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(kbpi_pkg::OFS_SC, 32'h0, "status control reset");
    rd(kbpi_pkg::OFS_PE, 32'h0, "pin enables reset");
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    // pin sharing: pins 7:4 active high, pin 7 on the adc
    en = 8'h3f;
    pol = 8'hf0;
    wr(kbpi_pkg::OFS_SC, {24'h0, pol});
    wr(kbpi_pkg::OFS_PE, {24'h0, en});
    settle();
    check("pad oe", pad_oe, 8'h40);
    check("pull up", pull_up, 8'h0f);
    check("pull down", pull_down, 8'h30);
    check("port in", port_in_data, 8'h0c);
    check("pad out", pad_out, 8'ha5);
    // edge mode: pin 4 rising, pin 0 falling, interrupt enabled
    wr(kbpi_pkg::OFS_PE, 32'h11);
    wr(kbpi_pkg::OFS_SC, 32'hf2);
    press <= 8'h02;
    settle();
    rd(kbpi_pkg::OFS_SC, 32'hf2, "disabled pin no flag");
    press <= 8'h10;
    settle();
    check("irq on flag", kb_irq, 1'b1);
    rd(kbpi_pkg::OFS_SC, 32'hfa, "rising flag");
    wr(kbpi_pkg::OFS_SC, 32'hf6);
    rd(kbpi_pkg::OFS_SC, 32'hf2, "ack clears");
    press <= 8'h01;
    settle();
    rd(kbpi_pkg::OFS_SC, 32'hfa, "falling flag");
    wr(kbpi_pkg::OFS_SC, 32'hf6);
    press <= 8'h00;
    settle();
    rd(kbpi_pkg::OFS_SC, 32'hf2, "pin 0 rising ignored");
    // event status, mask and edge event interrupt
    check("irq masked", irq, 1'b0);
    rd(kbpi_pkg::OFS_IST, 32'h1, "edge status");
    wr(kbpi_pkg::OFS_IMSK, 32'h1);
    settle();
    check("irq unmasked", irq, 1'b1);
    wr(kbpi_pkg::OFS_IST, 32'h1);
    settle();
    check("irq cleared", irq, 1'b0);
    rd(kbpi_pkg::OFS_IST, 32'h0, "status cleared");
    // level mode: held pin keeps the flag, ack refused
    wr(kbpi_pkg::OFS_SC, 32'hf3);
    press <= 8'h01;
    wait_m <= 1'b1;
    settle();
    check("wake from wait", wake, 1'b1);
    wr(kbpi_pkg::OFS_SC, 32'hf7);
    rd(kbpi_pkg::OFS_SC, 32'hfb, "level holds flag");
    rd(kbpi_pkg::OFS_IST, 32'h3, "ack refused");
    wr(kbpi_pkg::OFS_IST, 32'h3);
    press <= 8'h00;
    wait_m <= 1'b0;
    settle();
    wr(kbpi_pkg::OFS_SC, 32'hf5);
    rd(kbpi_pkg::OFS_SC, 32'hf1, "released ack clears");
    // stop mode: asynchronous level wake with interrupt disabled
    stop_m <= 1'b1;
    press <= 8'h10;
    settle();
    check("no irq polling", kb_irq, 1'b0);
    check("wake from stop", wake, 1'b1);
    press <= 8'h00;
    stop_m <= 1'b0;
    settle();
    conclude();
  end
endmodule
